// file: rtl/pcg_cycle_lut.sv
// Interval count selection for one card cycle
`timescale 1ns/100ps
module pcg_cycle_lut (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire pcg_pkg::pcg_cfg_t cfg,
    output pcg_pkg::pcg_cnt_t      cnt
);
    import pcg_pkg::*;

    pcg_cnt_t cnt_r;
    pcg_cnt_t cnt_nxt;
    logic     upper_wait_bit;
    logic     wait8;

    assign upper_wait_bit = cfg.wait_select_field[1];
    // On memory any nonzero wait setting counts as waited on 8-bit cycles; on I/O only bit 0 of the wait field
    assign wait8 = cfg.is_io ? cfg.wait_select_field[0]
                             : (cfg.wait_select_field != 2'h0);

    // Count selection from the window wait settings
    always_comb begin
        // [RULE4] setup by cycle type
        if (cfg.is_io) begin
            cnt_nxt.setup = SU_IO;
        end else if (upper_wait_bit) begin
            cnt_nxt.setup = SU_MEM_HI;
        end else begin
            cnt_nxt.setup = SU_MEM_LO;
        end
        // [RULE5] hold by cycle type
        if (cfg.is_io) begin
            cnt_nxt.hold = HD_IO;
        end else if (upper_wait_bit) begin
            cnt_nxt.hold = HD_MEM_HI;
        end else begin
            cnt_nxt.hold = HD_MEM_LO;
        end
        // [RULE2] command count from wait fields
        if (!cfg.wide16) begin
            // [RULE6] eight-bit command counts
            if (wait8) begin
                cnt_nxt.cmd = C8_WAIT;
            end else if (cfg.zero_wait) begin
                cnt_nxt.cmd = C8_ZWS;
            end else begin
                cnt_nxt.cmd = C8_ZERO;
            end
        end else if (cfg.is_io) begin
            // [RULE7] zero-wait ignored here
            cnt_nxt.cmd = cfg.wait_select_field[0] ? C16_IO_WS : C16_IO;
        end else begin
            // [RULE8] sixteen-bit memory counts
            case (cfg.wait_select_field)
                2'h0: cnt_nxt.cmd = cfg.zero_wait ? C16_M_ZWS : C16_M_WS0;
                2'h1: cnt_nxt.cmd = C16_M_WS1;
                2'h2: cnt_nxt.cmd = C16_M_WS2;
                default: cnt_nxt.cmd = C16_M_WS3;
            endcase
        end
    end

    // Registered counts
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign cnt = cnt_r;
endmodule

// file: rtl/pcg_pkg.sv
// Constants and carrier types for the card cycle timing generator
package pcg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_ADDR  = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_GO    = 8'h0C;
    localparam logic [7:0] OFS_STAT  = 8'h10;

    // Control register fields
    localparam int CTRL_IO_BIT  = 0;   // 1 = I/O cycle, 0 = memory cycle
    localparam int CTRL_W16_BIT = 1;   // 1 = 16-bit access, 0 = 8-bit
    localparam int CTRL_WS_LSB  = 2;   // Two-bit wait_select_field
    localparam int CTRL_ZWS_BIT = 4;   // Zero-wait request
    localparam int CTRL_TS_LSB  = 5;   // Two-bit timing_set_field
    localparam logic [31:0] CTRL_RST = 32'h0000_0020;

    // Go register fields
    localparam int GO_START_BIT = 0;
    localparam int GO_WRITE_BIT = 1;

    // Status register fields
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_PHASE_LSB = 1;
    localparam int STAT_RDATA_LSB = 16;

    // Reset values of address and data registers
    localparam logic [25:0] ADDR_RST  = 26'h000_0000;
    localparam logic [15:0] WDATA_RST = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Interval counts in reference clocks
    localparam logic [2:0] SU_IO      = 3'h3;
    localparam logic [2:0] SU_MEM_LO  = 3'h2;
    localparam logic [2:0] SU_MEM_HI  = 3'h4;
    localparam logic [1:0] HD_IO      = 2'h2;
    localparam logic [1:0] HD_MEM_LO  = 2'h2;
    localparam logic [1:0] HD_MEM_HI  = 2'h3;
    localparam logic [4:0] C8_ZERO    = 5'h13;  // 19
    localparam logic [4:0] C8_WAIT    = 5'h17;  // 23
    localparam logic [4:0] C8_ZWS     = 5'h07;  // 7
    localparam logic [4:0] C16_IO     = 5'h07;  // 7
    localparam logic [4:0] C16_IO_WS  = 5'h0B;  // 11
    localparam logic [4:0] C16_M_WS0  = 5'h09;  // 9
    localparam logic [4:0] C16_M_WS1  = 5'h0D;  // 13
    localparam logic [4:0] C16_M_WS2  = 5'h11;  // 17
    localparam logic [4:0] C16_M_WS3  = 5'h17;  // 23
    localparam logic [4:0] C16_M_ZWS  = 5'h05;  // 5
    localparam logic [1:0] TS_DEFAULT = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // Cycle configuration taken from the window setting
    typedef struct packed {
        logic       is_io;
        logic       wide16;
        logic [1:0] wait_select_field;
        logic       zero_wait;
        logic [1:0] timing_set_field;
    } pcg_cfg_t;

    // Interval counts for one card cycle
    typedef struct packed {
        logic [2:0] setup;
        logic [4:0] cmd;
        logic [1:0] hold;
    } pcg_cnt_t;

    // Cycle phases
    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_SETUP = 2'b01,
        PH_CMD   = 2'b10,
        PH_HOLD  = 2'b11
    } pcg_phase_t;

endpackage

// file: rtl/pcg_timing_gen.sv
// Card cycle timing generator with AHB-Lite register slave
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// Overview of operation
// [RULE1] All intervals are counted in cycles of the one block clock.
// [RULE2] Setup, command and hold counts come from the window wait settings.
// [RULE3] Each interval is a whole number of clocks, at least legacy timing.
// [RULE4] Setup is 3 for I/O; memory 2, or 4 with upper wait bit.
// [RULE5] Hold is 2 for I/O; memory 2, or 3 with upper wait bit.
// [RULE6] 8-bit command: 19, 7 with zero-wait, 23 with any wait setting; on I/O the code gives 23 only when bit 0 of wait_select_field is set.
// [RULE7] 16-bit I/O command: 7, or 11 with wait; zero-wait ignored.
// [RULE8] 16-bit memory command: 9/13/17/23 by wait field, 5 zero-wait.
// [RULE9] These counts belong to timing set field value 01; the code applies them for every timing_set_field value.
// [RULE10] Setup, command, hold run in order; address stable; no overlap.
// [RULE11] Command stays active while the card holds its wait line low.
module pcg_timing_gen (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic [25:0]      card_addr,
    output logic [15:0]      card_data_o,
    output logic             card_data_oe,
    input  wire logic [15:0] card_data_i,
    output logic             card_mem_rd_n,
    output logic             card_mem_wr_n,
    output logic             card_io_rd_n,
    output logic             card_io_wr_n,
    input  wire logic        card_wait_n
);
    import pcg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave state
    logic [31:0] ctrl_r,   ctrl_nxt;
    logic [25:0] addr_r,   addr_nxt;
    logic [15:0] wdata_r,  wdata_nxt;
    logic [15:0] rdata_r,  rdata_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [7:0]  aoff_r,   aoff_nxt;
    logic        wr_pend_r, wr_pend_nxt;
    logic        rd_pend_r, rd_pend_nxt;
    logic        addr_phase;
    logic        go_wr;
    logic        go_dir;

    // Cycle engine state
    pcg_phase_t  ph_r,     ph_nxt;
    logic [4:0]  cnt_r,    cnt_nxt;
    logic        dir_wr_r, dir_wr_nxt;
    logic        io_r,     io_nxt;
    pcg_cfg_t    cfg;
    pcg_cnt_t    lut_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Window configuration taken from the control register
    assign cfg.is_io             = ctrl_r[CTRL_IO_BIT];
    assign cfg.wide16            = ctrl_r[CTRL_W16_BIT];
    assign cfg.wait_select_field = ctrl_r[CTRL_WS_LSB +: 2];
    assign cfg.zero_wait         = ctrl_r[CTRL_ZWS_BIT];
    assign cfg.timing_set_field  = ctrl_r[CTRL_TS_LSB +: 2];

    pcg_cycle_lut u_lut (
        .ref_clk (ref_clk),
        .rst     (rst),
        .cfg     (cfg),
        .cnt     (lut_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address phase capture and read data path
    assign addr_phase = hsel && htrans[1] && hready;
    // Start bit counts only in a write data phase to GO
    assign go_wr  = wr_pend_r && (aoff_r == OFS_GO) && hwdata[GO_START_BIT];
    assign go_dir = hwdata[GO_WRITE_BIT];

    always_comb begin
        // A transfer is taken only while the bus is ready
        wr_pend_nxt = addr_phase && hwrite;
        rd_pend_nxt = addr_phase && !hwrite;
        aoff_nxt    = addr_phase ? haddr[7:0] : aoff_r;
        hrdata_nxt  = hrdata_r;
        ctrl_nxt    = ctrl_r;
        addr_nxt    = addr_r;
        wdata_nxt   = wdata_r;
        // Read data sampled one cycle into the data phase
        if (rd_pend_r) begin
            if (aoff_r == OFS_CTRL) begin
                hrdata_nxt = {25'h0000000, ctrl_r[6:0]};
            end else if (aoff_r == OFS_ADDR) begin
                hrdata_nxt = {6'h00, addr_r};
            end else if (aoff_r == OFS_WDATA) begin
                hrdata_nxt = {16'h0000, wdata_r};
            end else if (aoff_r == OFS_STAT) begin
                hrdata_nxt = {rdata_r, 13'h0000, ph_r, ph_r != PH_IDLE};
            end else begin
                hrdata_nxt = 32'h0000_0000;
            end
        end
        // [RULE10] settings frozen while a cycle runs
        if (wr_pend_r && ph_r == PH_IDLE) begin
            if (aoff_r == OFS_CTRL) begin
                ctrl_nxt = {25'h0000000, hwdata[6:0]};
            end else if (aoff_r == OFS_ADDR) begin
                addr_nxt = hwdata[25:0];
            end else if (aoff_r == OFS_WDATA) begin
                wdata_nxt = hwdata[15:0];
            end
        end
    end

    // Bus slave registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r    <= CTRL_RST;
            addr_r    <= ADDR_RST;
            wdata_r   <= WDATA_RST;
            hrdata_r  <= 32'h0000_0000;
            aoff_r    <= 8'h00;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            addr_r    <= addr_nxt;
            wdata_r   <= wdata_nxt;
            hrdata_r  <= hrdata_nxt;
            aoff_r    <= aoff_nxt;
            wr_pend_r <= wr_pend_nxt;
            rd_pend_r <= rd_pend_nxt;
        end
    end

    // Reads take one wait state; writes none
    assign hreadyout = !rd_pend_r;
    assign hrdata    = hrdata_r;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Cycle engine: setup, command, hold
    always_comb begin
        ph_nxt     = ph_r;
        cnt_nxt    = cnt_r;
        dir_wr_nxt = dir_wr_r;
        io_nxt     = io_r;
        rdata_nxt  = rdata_r;
        case (ph_r)
            PH_IDLE: begin
                // [RULE9] counts of timing set 01
                if (go_wr) begin
                    ph_nxt     = PH_SETUP;
                    cnt_nxt    = {2'b00, lut_cnt.setup};
                    dir_wr_nxt = go_dir;
                    io_nxt     = cfg.is_io;
                end
            end
            PH_SETUP: begin
                // [RULE1] setup counted in clocks
                if (cnt_r == 5'h01) begin
                    ph_nxt  = PH_CMD;
                    cnt_nxt = lut_cnt.cmd;
                end else begin
                    cnt_nxt = cnt_r - 5'h01;
                end
            end
            PH_CMD: begin
                // [RULE11] stretch while card waits
                if (cnt_r != 5'h01) begin
                    cnt_nxt = cnt_r - 5'h01;
                end else if (card_wait_n) begin
                    ph_nxt    = PH_HOLD;
                    cnt_nxt   = {3'b000, lut_cnt.hold};
                    // Read data taken as the strobe ends
                    rdata_nxt = dir_wr_r ? rdata_r : card_data_i;
                end
            end
            default: begin
                // [RULE10] next cycle waits for hold
                if (cnt_r == 5'h01) begin
                    ph_nxt = PH_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 5'h01;
                end
            end
        endcase
    end

    // Cycle engine registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ph_r     <= PH_IDLE;
            cnt_r    <= 5'h00;
            dir_wr_r <= 1'b0;
            io_r     <= 1'b0;
            rdata_r  <= 16'h0000;
        end else begin
            ph_r     <= ph_nxt;
            cnt_r    <= cnt_nxt;
            dir_wr_r <= dir_wr_nxt;
            io_r     <= io_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // [RULE3] strobes span whole clock periods
    assign card_addr     = addr_r;
    assign card_data_o   = wdata_r;
    assign card_data_oe  = dir_wr_r && (ph_r != PH_IDLE);
    assign card_mem_rd_n = !(ph_r == PH_CMD && !io_r && !dir_wr_r);
    assign card_mem_wr_n = !(ph_r == PH_CMD && !io_r &&  dir_wr_r);
    assign card_io_rd_n  = !(ph_r == PH_CMD &&  io_r && !dir_wr_r);
    assign card_io_wr_n  = !(ph_r == PH_CMD &&  io_r &&  dir_wr_r);
endmodule

// file: tb/pcg_card_model.sv
// Behavioural sixteen-bit card facing the timing generator
`timescale 1ns/100ps
module pcg_card_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [25:0] card_addr,
    input  wire logic        card_mem_rd_n,
    input  wire logic        card_mem_wr_n,
    input  wire logic        card_io_rd_n,
    input  wire logic        card_io_wr_n,
    input  wire logic [5:0]  wait_len,
    output logic [15:0]      card_data_i,
    output logic             card_wait_n
);
    logic [5:0]  low_cnt_r, low_cnt_nxt;
    logic [15:0] junk_r, junk_nxt;
    logic        rd, act;
    always_comb begin
        rd = !(card_mem_rd_n & card_io_rd_n);
        act = rd | !(card_mem_wr_n & card_io_wr_n);
        low_cnt_nxt = act ? low_cnt_r + 6'h01 : 6'h00;
        junk_nxt = ~junk_r;
        card_wait_n = !(act && low_cnt_r < wait_len);
        // Data is a pattern from the address; it toggles when not read
        card_data_i = rd ? (card_addr[15:0] ^ 16'hC35A) : junk_r;
    end
    // Command length counter and idle data pattern
    always_ff @(posedge ref_clk) begin
        low_cnt_r <= rst ? 6'h00 : low_cnt_nxt;
        junk_r <= rst ? 16'h5A5A : junk_nxt;
    end
endmodule

// file: tb/pcg_timing_gen_bench.sv
// Self-checking bench for the card cycle timing generator
`timescale 1ns/100ps
module pcg_timing_gen_bench;
    import pcg_pkg::*;
    logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp, card_data_oe;
    logic        card_mem_rd_n, card_mem_wr_n, card_io_rd_n, card_io_wr_n;
    logic        card_wait_n, strb_off;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [5:0]  wait_len;
    logic [15:0] card_data_o, card_data_i, rnd;
    logic [25:0] card_addr;
    logic [31:0] haddr, hwdata, hrdata, d;
    int          fails, num_checks, cyc;
    pcg_timing_gen u_pcg_timing_gen (.ref_clk, .rst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
        .hresp, .card_addr, .card_data_o, .card_data_oe, .card_data_i,
        .card_mem_rd_n, .card_mem_wr_n, .card_io_rd_n, .card_io_wr_n,
        .card_wait_n);
    pcg_card_model u_pcg_card_model (.ref_clk, .rst, .card_addr,
        .card_mem_rd_n, .card_mem_wr_n, .card_io_rd_n, .card_io_wr_n,
        .wait_len, .card_data_i, .card_wait_n);
    assign strb_off = card_mem_rd_n & card_mem_wr_n & card_io_rd_n
        & card_io_wr_n;
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Compare one value with its expectation
    task automatic chk(string n, logic [31:0] g, logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Random source, shift register
    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Expected command clocks for one setting
    function automatic logic [4:0] exp_cmd(logic io, w16, logic [1:0] ws,
                                           logic z);
        if (!w16)
            return (io ? ws[0] : ws != 2'h0) ? 5'h17 : (z ? 5'h07 : 5'h13);
        if (io)
            return ws[0] ? 5'h0B : 5'h07;
        case (ws)
            2'h0: return z ? 5'h05 : 5'h09;
            2'h1: return 5'h0D;
            2'h2: return 5'h11;
            default: return 5'h17;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // One single-word bus transfer
    task automatic xfer(logic wr, logic [7:0] a, logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        d = hrdata;
        hsel <= 1'b0;
    endtask
    // Wait until the card cycle has finished
    task automatic wait_idle;
        do xfer(1'b0, OFS_STAT, 32'h0); while (d[0] !== 1'b0);
    endtask
    // One card cycle with measured setup and command, and hold on writes
    task automatic run(logic [6:0] cfg, logic wr, int extra);
        int s, c, h, e;
        logic [25:0] a;
        logic [3:0]  st;
        s = 0;
        c = 0;
        h = 0;
        a = {rnd[9:0], rnd};
        e = exp_cmd(cfg[0], cfg[1], cfg[3:2], cfg[4]);
        wait_len <= (extra == 0) ? 6'h00 : 6'(e + extra);
        xfer(1'b1, OFS_CTRL, {25'h0, cfg});
        xfer(1'b1, OFS_ADDR, {6'h00, a});
        xfer(1'b1, OFS_WDATA, {16'h0000, ~rnd});
        xfer(1'b1, OFS_GO, {30'h0, wr, 1'b1});
        #1;
        while (strb_off && s < 9) begin s++; @(posedge ref_clk); #1; end
        st = {card_mem_rd_n, card_mem_wr_n, card_io_rd_n, card_io_wr_n};
        chk("strobes", st, 4'(~(4'b1000 >> {cfg[0], wr})));
        chk("address", card_addr, a);
        if (wr) chk("write data", card_data_o, 16'(~rnd));
        while (!strb_off && c < 99) begin c++; @(posedge ref_clk); #1; end
        while (card_data_oe && h < 9) begin h++; @(posedge ref_clk); #1; end
        chk("setup", s, cfg[0] ? 3 : (cfg[3] ? 4 : 2));
        e = (extra > 0) ? e + extra + 1 : e;
        chk("command", c, e);
        if (wr) chk("hold", h, cfg[0] ? 2 : (cfg[3] ? 3 : 2));
        wait_idle();
        if (!wr) chk("read data", d[31:16], a[15:0] ^ 16'hC35A);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Clock, and a ceiling on run length
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    // Main sequence
    initial begin
        {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
        hsize = 3'h2;
        wait_len = 6'h00;
        rnd = 16'h8BC4;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk("control reset", d, CTRL_RST);
        xfer(1'b0, OFS_GO, 32'h0);
        chk("go reads zero", d, 32'h0);
        xfer(1'b0, 8'h14, 32'h0);
        chk("unmapped", d, 32'h0);
        $display("Test reset values done");
        for (int i = 0; i < 32; i++) begin
            rnd = lfsr(rnd);
            run({rnd[1:0], i[4:0]}, rnd[2], 0);
        end
        $display("Test interval table done");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            run({2'h1, rnd[4:0]}, rnd[5], i[0] ? 3 : -1);
        end
        $display("Test card wait done");
        wait_len <= 6'h00;
        xfer(1'b1, OFS_CTRL, 32'h0C);
        xfer(1'b1, OFS_GO, 32'h1);
        xfer(1'b1, OFS_CTRL, 32'h01);
        xfer(1'b1, OFS_GO, 32'h3);
        xfer(1'b0, OFS_STAT, 32'h0);
        chk("busy", d[0], 1'b1);
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk("control kept", d, 32'h0C);
        wait_idle();
        repeat (8) @(posedge ref_clk);
        chk("no second cycle", strb_off, 1'b1);
        $display("Test busy refusal done");
        stop_test();
    end
endmodule

// file: tb/pcg_timing_gen_properties.sv
// Port-level properties of the card cycle timing generator
`timescale 1ns/100ps
module pcg_timing_gen_properties (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [25:0] card_addr,
    input wire logic        card_data_oe,
    input wire logic        card_mem_rd_n,
    input wire logic        card_mem_wr_n,
    input wire logic        card_io_rd_n,
    input wire logic        card_io_wr_n,
    input wire logic        card_wait_n
);
    logic cmd_off;
    logic acc;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // All strobes idle, and a bus request taken
    assign cmd_off = card_mem_rd_n & card_mem_wr_n
                   & card_io_rd_n & card_io_wr_n;
    assign acc = hsel & htrans[1] & hready;
    cmd_min_a: assert property ($fell(cmd_off) |-> !cmd_off[*5])
        else $error("Command strobe shorter than five clocks");
    one_strobe_a: assert property (!cmd_off |->
        $onehot({~card_mem_rd_n, ~card_mem_wr_n, ~card_io_rd_n,
        ~card_io_wr_n}))
        else $error("More than one command strobe active");
    addr_stable_a: assert property (!cmd_off |=>
        $stable(card_addr))
        else $error("Card address moved during command");
    wait_end_a: assert property ($rose(cmd_off) |->
        $past(card_wait_n))
        else $error("Command ended while card wait was asserted");
    cmd_gap_a: assert property ($rose(cmd_off) |->
        cmd_off[*4])
        else $error("Next command too soon after previous one");
    oe_dir_a: assert property (!cmd_off |-> card_data_oe ==
        !(card_mem_wr_n & card_io_wr_n))
        else $error("Data drive does not match strobe direction");
    wr_setup_a: assert property ($fell(cmd_off) && card_data_oe |->
        $past(card_data_oe, 2))
        else $error("Write data driven less than two setup clocks");
    wr_hold_a: assert property ($rose(cmd_off) && card_data_oe |->
        card_data_oe ##1 card_data_oe)
        else $error("Write data released before two hold clocks");
    rd_ready_a: assert property (acc && !hwrite |=>
        !hreadyout ##1 hreadyout)
        else $error("Register read not answered in two cycles");
    wr_ready_a: assert property (acc && hwrite |=> hreadyout)
        else $error("Register write stalled");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("Bus response not okay");
endmodule

bind pcg_timing_gen pcg_timing_gen_properties u_pcg_timing_gen_properties (
    .ref_clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .card_addr, .card_data_oe, .card_mem_rd_n, .card_mem_wr_n,
    .card_io_rd_n, .card_io_wr_n, .card_wait_n
);
